// ==== common/fsb_defs.svh ====
// Register offsets, field positions, reset values and timing for the
// flash safety and transmit-blank control block.
// Assumes a 40 MHz reference clock.
`ifndef FSB_DEFS_SVH
`define FSB_DEFS_SVH

`define FSB_ADDR_TIMING 8'h0a
`define FSB_ADDR_THERM 8'h0b
`define FSB_ADDR_BLANK 8'h0c

`define FSB_RST_TIMING 8'h00
`define FSB_RST_THERM 8'h00
`define FSB_RST_BLANK 8'hc0

// Writable bits of the thermal guard register; the rest read as zero
`define FSB_THERM_MASK 8'h8f

`define FSB_WATCHDOG_ENABLE_BIT 7
`define FSB_WDT_PER_HI 6
`define FSB_WDT_PER_LO 5
`define FSB_MODE_BIT 4
`define FSB_DUR_HI 3
`define FSB_DUR_LO 0

`define FSB_RST_CTL_BIT 7
`define FSB_BURN_EN_BIT 3
`define FSB_BURN_THR_HI 2
`define FSB_BURN_THR_LO 0

`define FSB_BLANK_EN_BIT 7
`define FSB_BLANK_POL_BIT 6
`define FSB_ILIM_HI 5
`define FSB_ILIM_LO 2
`define FSB_RECOV_HI 1
`define FSB_RECOV_LO 0

`define FSB_CLK_KHZ 40000
`define FSB_SAFETY_STEP_MS 50
`define FSB_SAFETY_STEP_CYC (`FSB_SAFETY_STEP_MS * `FSB_CLK_KHZ)
`define FSB_WDT_STEP_S 4
`define FSB_WDT_STEP_CYC (`FSB_WDT_STEP_S * 1000 * `FSB_CLK_KHZ)
`define FSB_PIN_LOW_MS 30
`define FSB_PIN_LOW_CYC (`FSB_PIN_LOW_MS * `FSB_CLK_KHZ)
`define FSB_RECOV_STEP_US 10
`define FSB_RECOV_STEP_CYC (`FSB_RECOV_STEP_US * `FSB_CLK_KHZ / 1000)

`endif

// ==== common/fsb_pkg.sv ====
// Types for the flash safety and transmit-blank control block.
// Assumes nothing of its surroundings.
package fsb_pkg;

  typedef enum logic [1:0] {
    fsb_st_idle  = 2'b00,
    fsb_st_fire  = 2'b01,
    fsb_st_done  = 2'b11,
    fsb_st_pdown = 2'b10
  } fsb_state_t;

endpackage

// ==== design/fsb_hold_timer.sv ====
// Level hold timer: reports when a level has stood for a set count.
// Assumes the level is synchronous to ref_clk.
`timescale 1ns/1ps

module fsb_hold_timer #(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] HOLD_CYC = 32'd1200000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Level under watch and result
  input wire logic level,
  output logic held
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Saturates at the hold count; any drop of the level restarts it
  always_comb begin
    cnt_nxt = cnt_r;
    if (!level) begin
      cnt_nxt = '0;
    end else if (cnt_r != HOLD_CYC) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign held = (cnt_r == HOLD_CYC);

endmodule // fsb_hold_timer

// ==== design/fsb_top.sv ====
// Flash safety timer, watchdog, finger-burn guard and transmit-blank
// current limit control, with its three settings registers.
// Assumes the serial interface delivers register accesses as strobes,
// and all pins arrive synchronous to ref_clk.
//
// Operation
// - Watchdog runs only while its enable bit is set.
// - Watchdog period codes 00..11 select 4, 8, 12, 16 s.
// - Single-flash mode gives one flash of exactly the safety duration.
// - Single-flash mode: logic supply low ends flash, enters power-down.
// - Maximum mode follows enables but cuts flash at safety duration.
// - Safety duration is 50 ms times code plus one.
// - Reset control clear: pin must stay low 30 ms to reset timer.
// - Reset control set: pin low resets the safety timer at once.
// - Thermistor input is evaluated only while burn guard is enabled.
// - Burn threshold is 200 mV plus 50 mV per code step.
// - Blank input honoured only while blank enable set; resets to one.
// - Polarity zero means blank active low, one means active high.
// - While blanked, input current capped at 50 mA per code step.
// - Recovery timer codes select 10, 20, 40, 80 us.
`timescale 1ns/1ps
`include "fsb_defs.svh"

module fsb_top
  import fsb_pkg::*;
#(
  parameter logic [31:0] SAFETY_STEP_CYC = `FSB_SAFETY_STEP_CYC,
  parameter logic [31:0] WDT_STEP_CYC = `FSB_WDT_STEP_CYC,
  parameter logic [31:0] PIN_LOW_CYC = `FSB_PIN_LOW_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register access from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Flash requests and supply
  input wire logic flash_i2c_req,
  input wire logic flash_pin_mode,
  input wire logic ext_flash_enable_pin,
  input wire logic logic_supply_ok,
  input wire logic watchdog_refresh,
  // Sensing inputs
  input wire logic burn_comp_trip,
  input wire logic tx_blank_input,
  // Control outputs
  output logic flash_on,
  output logic power_down,
  output logic regulators_off,
  output logic burn_fault,
  output logic [2:0] burn_threshold,
  output logic blank_active,
  output logic current_limit_active,
  output logic [3:0] blank_input_current_limit
);

  localparam logic [11:0] RECOV_STEP_CYC = 12'(`FSB_RECOV_STEP_CYC);

  // Settings registers
  logic [7:0] tim_r;
  logic [7:0] tim_nxt;
  logic [7:0] thr_r;
  logic [7:0] thr_nxt;
  logic [7:0] blk_r;
  logic [7:0] blk_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    tim_nxt = tim_r;
    thr_nxt = thr_r;
    blk_nxt = blk_r;
    if (reg_wr) begin
      case (reg_addr)
        `FSB_ADDR_TIMING: tim_nxt = reg_wdata;
        `FSB_ADDR_THERM: thr_nxt = reg_wdata & `FSB_THERM_MASK;
        `FSB_ADDR_BLANK: blk_nxt = reg_wdata;
        default: ;
      endcase
    end
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        `FSB_ADDR_TIMING: rdata_nxt = tim_r;
        `FSB_ADDR_THERM: rdata_nxt = thr_r;
        `FSB_ADDR_BLANK: rdata_nxt = blk_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tim_r <= `FSB_RST_TIMING;
      thr_r <= `FSB_RST_THERM;
      blk_r <= `FSB_RST_BLANK;
      rdata_r <= 8'h00;
    end else begin
      tim_r <= tim_nxt;
      thr_r <= thr_nxt;
      blk_r <= blk_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Field views
  logic watchdog_enable;
  logic [1:0] wdt_per;
  logic mode_max;
  logic [3:0] dur_code;
  logic rst_ctl;
  logic burn_en;
  logic blank_en;
  logic blank_pol;
  logic [1:0] recov_code;

  assign watchdog_enable = tim_r[`FSB_WATCHDOG_ENABLE_BIT];
  assign wdt_per = tim_r[`FSB_WDT_PER_HI:`FSB_WDT_PER_LO];
  assign mode_max = tim_r[`FSB_MODE_BIT];
  assign dur_code = tim_r[`FSB_DUR_HI:`FSB_DUR_LO];
  assign rst_ctl = thr_r[`FSB_RST_CTL_BIT];
  assign burn_en = thr_r[`FSB_BURN_EN_BIT];
  assign blank_en = blk_r[`FSB_BLANK_EN_BIT];
  assign blank_pol = blk_r[`FSB_BLANK_POL_BIT];
  assign recov_code = blk_r[`FSB_RECOV_HI:`FSB_RECOV_LO];
  assign burn_threshold = thr_r[`FSB_BURN_THR_HI:`FSB_BURN_THR_LO];
  assign blank_input_current_limit = blk_r[`FSB_ILIM_HI:`FSB_ILIM_LO];

  // Watchdog
  logic [31:0] wdt_limit;
  logic [31:0] wcnt_r;
  logic [31:0] wcnt_nxt;
  logic wexp_r;
  logic wexp_nxt;
  logic wdt_hit;

  assign wdt_limit = 32'(WDT_STEP_CYC * (32'(wdt_per) + 32'h1));
  assign wdt_hit = watchdog_enable && (wcnt_r == wdt_limit - 32'h1);

  // Expiry wins over a refresh landing in the same cycle
  always_comb begin
    wcnt_nxt = wcnt_r + 32'h1;
    if (!watchdog_enable || watchdog_refresh || wdt_hit) begin
      wcnt_nxt = 32'h0;
    end
    wexp_nxt = watchdog_enable && (wdt_hit || (wexp_r && !watchdog_refresh));
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wcnt_r <= 32'h0;
      wexp_r <= 1'b0;
    end else begin
      wcnt_r <= wcnt_nxt;
      wexp_r <= wexp_nxt;
    end
  end

  assign regulators_off = wexp_r;

  // Finger-burn guard
  logic burn_r;
  logic burn_nxt;

  always_comb begin
    burn_nxt = burn_en && burn_comp_trip;
  end

  // Safety timer
  logic pin_low_held;
  logic flash_req;
  logic safety_reset;
  logic [31:0] safety_limit;
  logic [31:0] scnt_r;
  logic [31:0] scnt_nxt;
  fsb_state_t st_r;
  fsb_state_t st_nxt;
  logic flash_r;
  logic flash_nxt;

  fsb_hold_timer #(
    .CNT_W(32),
    .HOLD_CYC(PIN_LOW_CYC)
  ) u_pin_low (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .level(~ext_flash_enable_pin),
    .held(pin_low_held)
  );

  assign flash_req = flash_i2c_req | (flash_pin_mode & ext_flash_enable_pin);
  assign safety_limit = 32'(SAFETY_STEP_CYC * (32'(dur_code) + 32'h1));

  always_comb begin
    if (flash_pin_mode) begin
      safety_reset = rst_ctl ? ~ext_flash_enable_pin
                             : pin_low_held;
    end else begin
      safety_reset = ~flash_req;
    end
  end

  always_comb begin
    st_nxt = st_r;
    scnt_nxt = scnt_r;
    case (st_r)
      fsb_st_idle: begin
        scnt_nxt = 32'h0;
        if (flash_req && logic_supply_ok && !wexp_r) begin
          st_nxt = fsb_st_fire;
        end
      end
      fsb_st_fire: begin
        scnt_nxt = scnt_r + 32'h1;
        if (!mode_max && !logic_supply_ok) begin
          st_nxt = fsb_st_pdown;
        end else if (scnt_r == safety_limit - 32'h1) begin
          st_nxt = fsb_st_done;
        end else if (mode_max && safety_reset) begin
          st_nxt = fsb_st_idle;
        end
      end
      fsb_st_done: begin
        if (safety_reset) begin
          st_nxt = fsb_st_idle;
        end
      end
      fsb_st_pdown: begin
        if (logic_supply_ok && !flash_req) begin
          st_nxt = fsb_st_idle;
        end
      end
      default: st_nxt = fsb_st_idle;
    endcase
    // Single-flash mode ignores the enables once fired
    flash_nxt = (st_nxt == fsb_st_fire) && (!mode_max || flash_req) &&
                !wexp_nxt && !burn_nxt;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= fsb_st_idle;
      scnt_r <= 32'h0;
      flash_r <= 1'b0;
      burn_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      scnt_r <= scnt_nxt;
      flash_r <= flash_nxt;
      burn_r <= burn_nxt;
    end
  end

  assign flash_on = flash_r;
  assign power_down = (st_r == fsb_st_pdown);
  assign burn_fault = burn_r;

  // Transmit blank and recovery
  logic blank_r;
  logic blank_nxt;
  logic [11:0] rcnt_r;
  logic [11:0] rcnt_nxt;
  logic lim_r;
  logic lim_nxt;

  always_comb begin
    blank_nxt = blank_en &&
                (blank_pol ? tx_blank_input : !tx_blank_input);
    rcnt_nxt = rcnt_r;
    if (blank_nxt) begin
      rcnt_nxt = 12'h000;
    end else if (blank_r) begin
      rcnt_nxt = RECOV_STEP_CYC << recov_code;
    end else if (rcnt_r != 12'h000) begin
      rcnt_nxt = rcnt_r - 12'h001;
    end
    lim_nxt = blank_nxt || (rcnt_nxt != 12'h000);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      blank_r <= 1'b0;
      rcnt_r <= 12'h000;
      lim_r <= 1'b0;
    end else begin
      blank_r <= blank_nxt;
      rcnt_r <= rcnt_nxt;
      lim_r <= lim_nxt;
    end
  end

  assign blank_active = blank_r;
  assign current_limit_active = lim_r;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  wdt_disabled_a: assert property (!watchdog_enable |=> !regulators_off)
    else $error("watchdog expired while disabled");
  wdt_period_a: assert property (watchdog_enable && !wexp_r && !watchdog_refresh &&
    wcnt_r == wdt_limit - 32'h1 ##1 watchdog_enable |-> regulators_off)
    else $error("watchdog did not expire at its period");
  oneshot_hold_a: assert property (st_r == fsb_st_fire && !mode_max &&
    logic_supply_ok && scnt_r != safety_limit - 32'h1 && !wexp_nxt &&
    !burn_nxt |=> flash_on)
    else $error("single flash ended early");
  pdown_entry_a: assert property (st_r == fsb_st_fire && !mode_max &&
    !logic_supply_ok |=> !flash_on && power_down)
    else $error("supply loss did not end the flash");
  max_cut_a: assert property (st_r == fsb_st_fire &&
    scnt_r == safety_limit - 32'h1 |=> !flash_on [*2])
    else $error("flash outlived the safety duration");
  dur_end_a: assert property (st_r == fsb_st_fire && !(!mode_max &&
    !logic_supply_ok) && scnt_r == safety_limit - 32'h1 |=>
    st_r == fsb_st_done)
    else $error("safety timer did not end at its count");
  pin_slow_a: assert property (st_r == fsb_st_done && flash_pin_mode &&
    !rst_ctl && !pin_low_held |=> st_r == fsb_st_done)
    else $error("safety timer reset before the low time");
  pin_fast_a: assert property (st_r == fsb_st_done && flash_pin_mode &&
    rst_ctl && !ext_flash_enable_pin |=> st_r == fsb_st_idle)
    else $error("safety timer not reset on pin low");
  burn_ignore_a: assert property (!burn_en |=> !burn_fault)
    else $error("burn input honoured while disabled");
  blank_gate_a: assert property (!blank_en |=> !blank_active)
    else $error("blank honoured while disabled");
  blank_low_a: assert property (blank_en && !blank_pol && !tx_blank_input
    |=> blank_active && current_limit_active)
    else $error("active-low blank not seen");
  recov_hold_a: assert property ($fell(blank_active) |->
    current_limit_active [*8])
    else $error("current limit released before recovery");

  wdt_expire_c: cover property (!regulators_off ##1 regulators_off);
  oneshot_c: cover property (st_r == fsb_st_fire && !mode_max
    ##1 st_r == fsb_st_done);
  pdown_c: cover property (st_r == fsb_st_fire ##1 power_down);
  recov_c: cover property ($fell(blank_active) ##8 current_limit_active);

endmodule // fsb_top

// ==== tb/fsb_host_model.sv ====
// Far-side model: host register strobes plus flash, supply and blank pins.
// Assumes the block samples every input on the rising edge of ref_clk.
`timescale 1ns/1ps

module fsb_host_model (
  // Clock
  input wire logic ref_clk,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Requests and pins
  output logic flash_i2c_req,
  output logic flash_pin_mode,
  output logic ext_flash_enable_pin,
  output logic logic_supply_ok,
  output logic watchdog_refresh,
  output logic burn_comp_trip,
  output logic tx_blank_input
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    flash_i2c_req = 1'b0;
    flash_pin_mode = 1'b0;
    ext_flash_enable_pin = 1'b0;
    logic_supply_ok = 1'b1;
    watchdog_refresh = 1'b0;
    burn_comp_trip = 1'b0;
    // Idle level of the blank pin under the reset polarity (active high)
    tx_blank_input = 1'b0;
  end

  // Level pins, changed by the bench just after a clock edge
  task automatic set_req(input logic v);
    flash_i2c_req = v;
  endtask

  task automatic set_mode(input logic v);
    flash_pin_mode = v;
  endtask

  task automatic set_en(input logic v);
    ext_flash_enable_pin = v;
  endtask

  task automatic set_supply(input logic v);
    logic_supply_ok = v;
  endtask

  task automatic set_burn(input logic v);
    burn_comp_trip = v;
  endtask

  task automatic set_blank(input logic v);
    tx_blank_input = v;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
    // Released data shows its inverse, not the stale byte
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    @(posedge ref_clk) #1;
    d = reg_rdata;
  endtask

  // Enable pin held low a set number of cycles, then raised
  task automatic pin_low(input int n);
    @(posedge ref_clk) #1;
    ext_flash_enable_pin = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    ext_flash_enable_pin = 1'b1;
  endtask

  task automatic refresh();
    @(posedge ref_clk) #1;
    watchdog_refresh = 1'b1;
    @(posedge ref_clk) #1;
    watchdog_refresh = 1'b0;
  endtask
endmodule // fsb_host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the flash safety and blank control block.
// Assumes the host model drives all inputs but clock and reset; timers but the recovery timer run shortened.
`timescale 1ns/1ps

module tb_top;
  localparam int SAF = 20;
  localparam int WDT = 50;
  logic ref_clk, arst_n, reg_wr, reg_rd, flash_i2c_req, flash_pin_mode;
  logic ext_flash_enable_pin, logic_supply_ok, watchdog_refresh;
  logic burn_comp_trip, tx_blank_input, flash_on, power_down;
  logic regulators_off, burn_fault, blank_active, current_limit_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0] burn_threshold;
  logic [3:0] blank_input_current_limit;
  int error_cnt, num_checks, n;

  fsb_top #(.SAFETY_STEP_CYC(32'd20), .WDT_STEP_CYC(32'd50),
    .PIN_LOW_CYC(32'd10)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .flash_i2c_req(flash_i2c_req), .flash_pin_mode(flash_pin_mode),
    .ext_flash_enable_pin(ext_flash_enable_pin),
    .logic_supply_ok(logic_supply_ok), .watchdog_refresh(watchdog_refresh),
    .burn_comp_trip(burn_comp_trip), .tx_blank_input(tx_blank_input),
    .flash_on(flash_on), .power_down(power_down),
    .regulators_off(regulators_off), .burn_fault(burn_fault),
    .burn_threshold(burn_threshold), .blank_active(blank_active),
    .current_limit_active(current_limit_active),
    .blank_input_current_limit(blank_input_current_limit));

  fsb_host_model u_host (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .flash_i2c_req(flash_i2c_req),
    .flash_pin_mode(flash_pin_mode),
    .ext_flash_enable_pin(ext_flash_enable_pin),
    .logic_supply_ok(logic_supply_ok), .watchdog_refresh(watchdog_refresh),
    .burn_comp_trip(burn_comp_trip), .tx_blank_input(tx_blank_input));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [11:0] exp,
      input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // Bounded wait for flash_on, then count how long it stands
  task automatic flash_len(output int len);
    int w;
    len = 0;
    for (w = 0; w < 20 && flash_on !== 1'b1; w++) cyc(1);
    while (flash_on === 1'b1 && len < 2000) begin
      len++;
      cyc(1);
    end
  endtask

  task automatic t_regs();
    u_host.rd(8'h0a, d); chk("timing reset", 12'h000, d);
    u_host.rd(8'h0b, d); chk("thermal reset", 12'h000, d);
    u_host.rd(8'h0c, d); chk("blank reset", 12'h0c0, d);
    u_host.rd(8'h0d, d); chk("unmapped read", 12'h000, d);
    u_host.wr(8'h0b, 8'hff);
    u_host.rd(8'h0b, d); chk("thermal mask", 12'h08f, d);
    chk("threshold", 12'h007, 12'(burn_threshold));
  endtask

  task automatic t_burn();
    u_host.wr(8'h0b, 8'h05);
    u_host.set_burn(1'b1);
    cyc(3); chk("burn ignored", 12'h0, 12'(burn_fault));
    chk("threshold", 12'h005, 12'(burn_threshold));
    u_host.wr(8'h0b, 8'h0d);
    cyc(3); chk("burn trip", 12'h1, 12'(burn_fault));
    u_host.set_burn(1'b0);
    u_host.wr(8'h0b, 8'h00);
    cyc(3); chk("burn clear", 12'h0, 12'(burn_fault));
  endtask

  // Assert blank, release it, measure how long the reduced limit holds
  task automatic blank_hold(input logic act, input int exp);
    u_host.set_blank(act);
    cyc(2); chk("blank on", 12'h1, 12'(blank_active));
    u_host.set_blank(~act);
    cyc(2); chk("limit held", 12'h1, 12'(current_limit_active));
    n = 0;
    while (current_limit_active === 1'b1 && n < 2000) begin
      n++;
      cyc(1);
    end
    chk("recovery", 12'h1, 12'(n >= exp - 4 && n <= exp + 2));
  endtask

  task automatic t_blank();
    u_host.wr(8'h0c, 8'h3c);
    chk("limit code", 12'h00f, 12'(blank_input_current_limit));
    u_host.set_blank(1'b0);
    cyc(3); chk("blank disabled", 12'h0, 12'(blank_active));
    u_host.set_blank(1'b1);
    u_host.wr(8'h0c, 8'hbc);
    blank_hold(1'b0, 400);
    u_host.wr(8'h0c, 8'hc1);
    blank_hold(1'b1, 800);
  endtask

  task automatic t_flash();
    logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hf};
    foreach (codes[i]) begin
      u_host.wr(8'h0a, {4'h0, codes[i]});
      u_host.set_req(1'b1);
      flash_len(n);
      chk("one-shot len", 12'(SAF * (codes[i] + 1)), 12'(n));
      cyc(5); chk("single flash", 12'h0, 12'(flash_on));
      u_host.set_req(1'b0);
      cyc(2);
    end
    chk("wdog idle", 12'h0, 12'(regulators_off));
    u_host.set_req(1'b1);
    cyc(10);
    // One-shot flash carries on after the request drops
    u_host.set_req(1'b0);
    cyc(3); chk("enable ignored", 12'h1, 12'(flash_on));
    u_host.set_supply(1'b0);
    cyc(2); chk("supply cut", 12'h0, 12'(flash_on));
    chk("power down", 12'h1, 12'(power_down));
    u_host.set_supply(1'b1);
    cyc(3);
    u_host.wr(8'h0a, 8'h10);
    u_host.set_req(1'b1);
    flash_len(n); chk("max len", 12'(SAF), 12'(n));
    u_host.set_req(1'b0);
    cyc(3);
    u_host.set_req(1'b1);
    cyc(4); chk("max follows", 12'h1, 12'(flash_on));
    u_host.set_req(1'b0);
    cyc(3); chk("max drop", 12'h0, 12'(flash_on));
  endtask

  task automatic t_pin();
    u_host.set_mode(1'b1);
    u_host.set_en(1'b1);
    flash_len(n); chk("pin len", 12'(SAF), 12'(n));
    u_host.pin_low(5);
    cyc(3); chk("short low", 12'h0, 12'(flash_on));
    u_host.pin_low(12);
    cyc(3); chk("long low", 12'h1, 12'(flash_on));
    flash_len(n);
    u_host.wr(8'h0b, 8'h80);
    u_host.pin_low(2);
    cyc(3); chk("quick reset", 12'h1, 12'(flash_on));
    u_host.set_en(1'b0);
    u_host.set_mode(1'b0);
    cyc(3);
  endtask

  task automatic t_wdog();
    u_host.wr(8'h0a, 8'h80);
    cyc(40);
    u_host.refresh();
    cyc(40); chk("refreshed", 12'h0, 12'(regulators_off));
    for (n = 0; n < 30 && regulators_off !== 1'b1; n++) cyc(1);
    chk("expiry", 12'h1, 12'(regulators_off));
    u_host.wr(8'h0a, 8'h00);
    cyc(2); chk("wdog off", 12'h0, 12'(regulators_off));
    u_host.wr(8'h0a, 8'ha0);
    cyc(2 * WDT - 12); chk("period", 12'h0, 12'(regulators_off));
    for (n = 0; n < 20 && regulators_off !== 1'b1; n++) cyc(1);
    chk("period end", 12'h1, 12'(regulators_off));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    arst_n = 1'b0;
    cyc(16);
    arst_n = 1'b1;
    t_regs();
    t_burn();
    t_blank();
    t_flash();
    t_pin();
    t_wdog();
    results();
  end
endmodule // tb_top
